/* eeprom_save_pseudo_end_sequencer.v */
/*
 * eeprom save sequencer: walks the selection buffer, copies registers into
 * the eeprom, pauses on the pseudo-end code and resumes at the kept address.
 * assumes the host writes the buffer through i_buf_* while idle, and that
 * register contents are read combinationally through o_reg_addr/i_reg_data.
 */
// Behaviour
// - selection buffer holds 23 bytes, room for seven groups per pass.
// - code 0xFE during a save is a pseudo-end, distinct from final end.
// - pseudo-end stops the transfer, clears save request, frees serial port.
// - resumed save continues writing at the eeprom address kept from before.
// - same register may be stored several times across paused passes.
// - end code 0xFF ends the transfer completely.
// - code 0x80 during restore copies buffer bank into active bank.
// - group is count-minus-one (max 128), then address low and high byte.
// - transfer status set at start, cleared at finish and at pause.
`timescale 1ns/100ps
`include "eeprom_save_defs.vh"

module eeprom_save_pseudo_end_sequencer (
	input  wire                  i_clk,
	input  wire                  i_rst,
	input  wire                  i_buf_we,
	input  wire [`BUF_AW-1:0]    i_buf_addr,
	input  wire [7:0]            i_buf_wdata,
	input  wire                  i_save_request_set,
	input  wire                  i_update_strobe,
	input  wire                  i_restore,
	input  wire [7:0]            i_reg_data,
	input  wire                  i_wr_done,
	output reg                   o_save_request_bit,
	output reg                   o_transfer_status,
	output reg                   o_serial_port_en,
	output reg                   o_bank_update,
	output reg                   o_save_complete,
	output reg  [15:0]           o_reg_addr,
	output wire                  o_wr_valid,
	output wire [7:0]            o_wr_data,
	output wire [`EE_AW-1:0]     o_wr_addr
);

	// -----------------------------------------------------------------
	// selection buffer
	// -----------------------------------------------------------------
	reg [7:0] buf_mem [0:`BUF_BYTES-1];
	integer k;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (k = 0; k < `BUF_BYTES; k = k + 1)
				buf_mem[k] <= `OP_END;
		end else if (i_buf_we && !o_transfer_status &&
				i_buf_addr < `BUF_BYTES) begin
			buf_mem[i_buf_addr] <= i_buf_wdata;
		end
	end

	// -----------------------------------------------------------------
	// opcode decoding
	// -----------------------------------------------------------------
	// the count field is seven bits; bit 7 never belongs to the count,
	// so a stray high bit cannot stretch a group past 128 bytes
	function [7:0] group_count;
		input [7:0] code;
		begin
			group_count = code & `MAX_GRP_COUNT;
		end
	endfunction

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	// one byte is in flight at a time: ST_ALO, ST_AHI, ST_COPY and ST_EMIT
	// wait until the writer is idle and no request is pending, while ST_CNT
	// and ST_FETCH issue without waiting but are only reached with the writer
	// idle, which keeps a gap of at least one cycle between eeprom writes.
	reg [2:0]          state_ff;
	reg [`BUF_AW-1:0]  ptr_ff;
	reg [7:0]          cnt_ff;
	reg [7:0]          alo_ff;
	reg [`EE_AW-1:0]   ee_addr_ff;
	reg                restore_ff;
	reg                req_ff;
	reg [7:0]          byte_ff;
	wire               wr_busy;
	wire               wr_done;
	wire [7:0]         cur = (ptr_ff < `BUF_BYTES) ? buf_mem[ptr_ff] : `OP_END;

	ee_byte_writer u_wr (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_req      (req_ff),
		.i_data     (byte_ff),
		.i_addr     (ee_addr_ff),
		.i_wr_done  (i_wr_done),
		.o_busy     (wr_busy),
		.o_done     (wr_done),
		.o_wr_valid (o_wr_valid),
		.o_wr_data  (o_wr_data),
		.o_wr_addr  (o_wr_addr)
	);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff           <= `ST_IDLE;
			ptr_ff             <= {`BUF_AW{1'b0}};
			cnt_ff             <= 8'h00;
			alo_ff             <= 8'h00;
			ee_addr_ff         <= `EE_ADDR_RST;
			restore_ff         <= 1'b0;
			req_ff             <= 1'b0;
			byte_ff            <= 8'h00;
			o_save_request_bit <= 1'b0;
			o_transfer_status  <= 1'b0;
			o_serial_port_en   <= 1'b1;
			o_bank_update      <= 1'b0;
			o_save_complete    <= 1'b0;
			o_reg_addr         <= 16'h0000;
		end else begin
			req_ff          <= 1'b0;
			o_bank_update   <= 1'b0;
			o_save_complete <= 1'b0;
			if (i_save_request_set)
				o_save_request_bit <= 1'b1;
			case (state_ff)
			`ST_IDLE: begin
				if ((o_save_request_bit && i_update_strobe) || i_restore) begin
					state_ff          <= `ST_FETCH;
					ptr_ff            <= {`BUF_AW{1'b0}};
					restore_ff        <= i_restore & ~o_save_request_bit;
					o_transfer_status <= 1'b1;
					o_serial_port_en  <= 1'b0;
					// ee_addr_ff kept from the last pass
				end
			end
			`ST_FETCH: begin
				if (cur == `OP_END) begin
					state_ff           <= `ST_IDLE;
					o_transfer_status  <= 1'b0;
					o_serial_port_en   <= 1'b1;
					o_save_request_bit <= 1'b0;
					o_save_complete    <= ~restore_ff;
					ee_addr_ff         <= `EE_ADDR_RST;
				end else if (cur == `OP_PSEUDO_END && !restore_ff) begin
					state_ff           <= `ST_IDLE;
					o_transfer_status  <= 1'b0;
					o_serial_port_en   <= 1'b1;
					o_save_request_bit <= 1'b0;
				end else if (cur == `OP_UPDATE) begin
					o_bank_update <= restore_ff;
					if (!restore_ff) begin
						byte_ff  <= cur;
						req_ff   <= 1'b1;
						state_ff <= `ST_EMIT;
					end
					ptr_ff <= ptr_ff + 1'b1;
				end else begin
					state_ff <= `ST_CNT;
				end
			end
			// -------------------------------------------------------------
			// group header: count, then address low and high byte
			// -------------------------------------------------------------
			`ST_CNT: begin
				cnt_ff   <= group_count(cur);
				byte_ff  <= group_count(cur);
				req_ff   <= ~restore_ff;
				ptr_ff   <= ptr_ff + 1'b1;
				state_ff <= `ST_ALO;
			end
			`ST_ALO: begin
				if (!wr_busy && !req_ff) begin
					alo_ff   <= cur;
					byte_ff  <= cur;
					req_ff   <= ~restore_ff;
					ptr_ff   <= ptr_ff + 1'b1;
					state_ff <= `ST_AHI;
				end
			end
			`ST_AHI: begin
				if (!wr_busy && !req_ff) begin
					o_reg_addr <= {cur, alo_ff};
					byte_ff    <= cur;
					req_ff     <= ~restore_ff;
					ptr_ff     <= ptr_ff + 1'b1;
					state_ff   <= restore_ff ? `ST_FETCH : `ST_COPY;
				end
			end
			`ST_COPY: begin
				if (!wr_busy && !req_ff) begin
					byte_ff  <= i_reg_data;
					req_ff   <= 1'b1;
					state_ff <= `ST_EMIT;
				end
			end
			`ST_EMIT: begin
				if (!wr_busy && !req_ff) begin
					if (cnt_ff == 8'h00) begin
						state_ff <= `ST_FETCH;
					end else begin
						cnt_ff     <= cnt_ff - 1'b1;
						o_reg_addr <= o_reg_addr + 1'b1;
						state_ff   <= `ST_COPY;
					end
				end
			end
			default: state_ff <= `ST_IDLE;
			endcase
			if (wr_done)
				ee_addr_ff <= ee_addr_ff + 1'b1;
		end
	end

endmodule

/* eeprom_save_defs.vh */
/*
 * constants for the eeprom save sequencer: opcodes, buffer size, field layout.
 * assumes it is included by bare name from the design files.
 */
`ifndef EEPROM_SAVE_DEFS_VH
`define EEPROM_SAVE_DEFS_VH

`define BUF_BYTES      23
`define BUF_AW         5
`define OP_PSEUDO_END  8'hFE
`define OP_END         8'hFF
`define OP_UPDATE      8'h80
`define GRP_BYTES      3
`define MAX_GRP_COUNT  8'h7F
`define EE_AW          9
`define EE_ADDR_RST    9'h000
`define ST_IDLE        3'h0
`define ST_FETCH       3'h1
`define ST_CNT         3'h2
`define ST_ALO         3'h3
`define ST_AHI         3'h4
`define ST_COPY        3'h5
`define ST_EMIT        3'h6

`endif

/* ee_byte_writer.v */
/*
 * one-byte write request holder toward the internal i2c master.
 * assumes the master pulses i_wr_done once per accepted byte.
 */
`timescale 1ns/100ps
`include "eeprom_save_defs.vh"

module ee_byte_writer (
	input  wire                  i_clk,
	input  wire                  i_rst,
	input  wire                  i_req,
	input  wire [7:0]            i_data,
	input  wire [`EE_AW-1:0]     i_addr,
	input  wire                  i_wr_done,
	output wire                  o_busy,
	output wire                  o_done,
	output wire                  o_wr_valid,
	output wire [7:0]            o_wr_data,
	output wire [`EE_AW-1:0]     o_wr_addr
);

	reg                 busy_ff;
	reg [7:0]           data_ff;
	reg [`EE_AW-1:0]    addr_ff;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_ff <= 1'b0;
			data_ff <= 8'h00;
			addr_ff <= `EE_ADDR_RST;
		end else if (!busy_ff && i_req) begin
			busy_ff <= 1'b1;
			data_ff <= i_data;
			addr_ff <= i_addr;
		end else if (busy_ff && i_wr_done) begin
			busy_ff <= 1'b0;
		end
	end

	assign o_busy     = busy_ff;
	assign o_done     = busy_ff & i_wr_done;
	assign o_wr_valid = busy_ff;
	assign o_wr_data  = data_ff;
	assign o_wr_addr  = addr_ff;

endmodule

/* seq_props.sv */
/* assertions for the save sequencer.
   assumes binding to the sequencer's ports. */
`timescale 1ns/100ps
module seq_props (
	input wire       i_clk,
	input wire       i_rst,
	input wire       i_update_strobe,
	input wire       i_wr_done,
	input wire       o_save_request_bit,
	input wire       o_transfer_status,
	input wire       o_serial_port_en,
	input wire       o_save_complete,
	input wire       o_wr_valid,
	input wire [7:0] o_wr_data,
	input wire [8:0] o_wr_addr
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_start;
		o_save_request_bit && i_update_strobe && !o_transfer_status;
	endsequence
	sequence s_take;
		o_wr_valid && i_wr_done;
	endsequence
	start_status_a: assert property (s_start |=> o_transfer_status)
		else $error("status not raised");
	start_write_a: assert property (s_start |-> ##[2:6] o_wr_valid)
		else $error("no first byte");
	port_busy_a: assert property (o_transfer_status |-> !o_serial_port_en)
		else $error("port on in transfer");
	pause_clear_a: assert property ($fell(o_transfer_status)
		|-> !o_save_request_bit && o_serial_port_en) else $error("bad pause");
	hold_req_a: assert property (o_wr_valid && !i_wr_done |=> o_wr_valid
		&& $stable(o_wr_data) && $stable(o_wr_addr)) else $error("req moved");
	byte_gap_a: assert property (s_take |=> !o_wr_valid)
		else $error("no gap");
	valid_busy_a: assert property (o_wr_valid |-> o_transfer_status)
		else $error("write outside transfer");
	end_done_a: assert property (o_save_complete
		|-> !o_transfer_status && !o_save_request_bit) else $error("bad end");
endmodule
bind eeprom_save_pseudo_end_sequencer seq_props seq_props_inst (.i_clk,
	.i_rst, .i_update_strobe, .i_wr_done, .o_save_request_bit,
	.o_transfer_status, .o_serial_port_en, .o_save_complete, .o_wr_valid,
	.o_wr_data, .o_wr_addr);

/* ee_model.sv */
/* eeprom behind an i2c master: stores a byte, then pulses done.
   assumes requests are held until done. */
`timescale 1ns/100ps
module ee_model (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_slow,
	input  wire       i_wr_valid,
	input  wire [7:0] i_wr_data,
	input  wire [8:0] i_wr_addr,
	output reg        o_wr_done
);
	reg [7:0] mem [0:511];
	reg [1:0] wait_ff;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wr_done <= 1'b0;
			wait_ff <= 2'h0;
		end else if (i_wr_valid && !o_wr_done && (!i_slow || &wait_ff)) begin
			o_wr_done <= 1'b1;
			mem[i_wr_addr] <= i_wr_data;
			wait_ff <= 2'h0;
		end else begin
			o_wr_done <= 1'b0;
			wait_ff <= wait_ff + {1'b0, i_wr_valid};
		end
	end
endmodule

/* eeprom_save_pseudo_end_sequencer_tb.sv */
/* bench for the save sequencer: paused and final passes, restore.
   assumes the eeprom model ee_model. */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module eeprom_save_pseudo_end_sequencer_tb;
	reg i_clk = 0, i_rst = 1, i_buf_we = 0, i_save_request_set = 0;
	reg i_update_strobe = 0, i_restore = 0, slow = 0, seen = 0, bu = 0;
	reg [4:0] i_buf_addr = 0;
	reg [7:0] i_buf_wdata = 0, c, lo, hi, op, val = 0;
	wire i_wr_done, o_save_request_bit, o_transfer_status, o_serial_port_en;
	wire o_bank_update, o_save_complete, o_wr_valid;
	wire [15:0] o_reg_addr;
	wire [7:0] o_wr_data, i_reg_data;
	wire [8:0] o_wr_addr;
	int mismatches = 0, cmp_count = 0, ptr = 0, k, t;
	reg [39:0] rows [4] = '{40'h00_1000_FE11, 40'h01_1000_FE22,
		40'h00_2000_FF33, 40'h00_0500_FE44};
	assign i_reg_data = o_reg_addr[7:0] ^ val;
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_save_complete) seen <= 1;
	always @(posedge i_clk) if (o_bank_update) bu <= 1;
	eeprom_save_pseudo_end_sequencer eeprom_save_pseudo_end_sequencer_inst (.*);
	ee_model ee_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow),
		.i_wr_valid(o_wr_valid), .i_wr_data(o_wr_data),
		.i_wr_addr(o_wr_addr), .o_wr_done(i_wr_done));
	task wb(input [4:0] a, input [7:0] d);
		@(negedge i_clk) {i_buf_we, i_buf_addr, i_buf_wdata} = {1'b1, a, d};
		@(negedge i_clk) i_buf_we = 0;
	endtask
	task print_verdict;
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200000 mismatches++;
		print_verdict;
	end
	initial begin
		repeat (6) @(negedge i_clk);
		i_rst = 0;
		`CHK({o_transfer_status, o_serial_port_en, o_wr_valid}, 3'b010)
		for (k = 0; k < 4; k++) begin
			{c, lo, hi, op, val} = rows[k];
			slow = k[0];
			seen = 0;
			wb(0, c); wb(1, lo); wb(2, hi); wb(3, op);
			@(negedge i_clk) i_save_request_set = 1;
			@(negedge i_clk) {i_save_request_set, i_update_strobe} = 2'b01;
			@(negedge i_clk) i_update_strobe = 0;
			for (t = 0; t < 400 && o_transfer_status; t++) @(negedge i_clk);
			@(negedge i_clk);
			`CHK(o_transfer_status, 1'b0)
			`CHK({o_save_request_bit, o_serial_port_en, seen}, {2'b01, op == 8'hFF})
			`CHK(ee_model_inst.mem[ptr], c)
			`CHK(ee_model_inst.mem[ptr + 1], lo)
			`CHK(ee_model_inst.mem[ptr + 2], hi)
			`CHK(ee_model_inst.mem[ptr + 3], lo ^ val)
			ptr = (op == 8'hFF) ? 0 : ptr + 4 + c;
		end
		wb(0, 8'h80); wb(1, 8'hFF);
		@(negedge i_clk) i_restore = 1;
		@(negedge i_clk) i_restore = 0;
		for (t = 0; t < 50 && !bu; t++) @(negedge i_clk);
		`CHK(bu, 1'b1)
		print_verdict;
	end
endmodule
